// ==== include/uev_defines.vh ====
`ifndef UEV_DEFINES_VH
`define UEV_DEFINES_VH

// register word addresses (8-bit address bus)
`define UEV_ADDR_SIE_RAW 8'h00
`define UEV_ADDR_SIE_EN 8'h01
`define UEV_ADDR_SIE_GATED 8'h02
`define UEV_ADDR_POWER 8'h03
`define UEV_ADDR_LPM_INFO 8'h04
`define UEV_ADDR_ARB_RAW_BASE 8'h10
`define UEV_ADDR_ARB_EN_BASE 8'h20
`define UEV_ADDR_ARB_GATED 8'h30
`define UEV_ADDR_EP_MODE_BASE 8'h40
`define UEV_ADDR_EP_CNT_HI_BASE 8'h50
`define UEV_ADDR_EP_CNT_LO_BASE 8'h60
`define UEV_ADDR_BUF_SIZE 8'h70
`define UEV_ADDR_DMA_REQ 8'h71
`define UEV_ADDR_EP_DIR 8'h72

// sie event bit positions
`define UEV_SIE_LPM 0
`define UEV_SIE_WAKE 1

// arbiter source bit positions
`define UEV_ARB_GRANT 0
`define UEV_ARB_INFULL 1
`define UEV_ARB_OVF 2
`define UEV_ARB_UNF 3
`define UEV_ARB_TERM 4

// transfer modes
`define UEV_MODE_MANUAL 2'h1
`define UEV_MODE_MANUAL_DMA 2'h2
`define UEV_MODE_AUTO 2'h3

// power states
`define UEV_PWR_ACTIVE 2'h0

// reset values
`define UEV_RST_WORD 32'h00000000
`define UEV_RST_MODE 2'h1

`endif

// ==== src/uev_event_ctrl.v ====
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "uev_defines.vh"
// Notes on behaviour
// - lowpower token sets lowpower event raw bit
// - lowpower gated equals enable and raw
// - lowpower exit only by a firmware power write
// - low level on d plus sets wake
// - wake gated equals enable and raw
// - wake detection only in active power state
// - five arbiter sources gated, ored to one
// - burst done after request sets grant
// - one grant flag per endpoint, shared
// - only first request forwarded while pending
// - in buffer full only for in endpoints
// - store-forward full when count reaches programmed
// - cut-through full when dedicated buffer fills
// - overflow only in cut-through mode
// - in dedicated overflow before in token
// - out dedicated overflow with common occupied
// - common area overflow, in or out
// - underflow only cut-through in endpoints
// - terminate signal sets termination status
// - eight endpoints, request vector, burst done
// - three transfer modes per endpoint
module uev_event_ctrl #(
    parameter NUM_EP = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // serial engine events, same clock
    input wire lpm_token_rx,
    input wire [3:0] lpm_besl,
    input wire lpm_remote_wake,
    input wire dp_pad,
    // buffer engine events, same clock
    input wire [NUM_EP-1:0] ep_byte_wr,
    input wire [NUM_EP-1:0] ep_in_token,
    input wire [NUM_EP-1:0] ep_out_done,
    input wire [NUM_EP-1:0] ep_common_ovf,
    input wire [NUM_EP-1:0] ep_dedicated_unf,
    input wire [NUM_EP-1:0] ep_common_unf,
    input wire [NUM_EP-1:0] ep_arb_dma_req,
    input wire [NUM_EP-1:0] ep_dma_termin,
    // dma controller handshake
    input wire [NUM_EP-1:0] dma_burst_done,
    output reg [NUM_EP-1:0] dma_req,
    // interrupt outputs
    output reg sie_irq,
    output reg arb_irq,
    output reg wake_request
);

// ==========================================
// synchronisers for pins
reg dp_s1_r;
reg dp_s2_r;
reg [NUM_EP-1:0] bd_s1_r;
reg [NUM_EP-1:0] bd_s2_r;
reg [NUM_EP-1:0] bd_d_r;
wire [NUM_EP-1:0] burst_pulse = bd_s2_r & ~bd_d_r;

// pad idles high, so a high reset value avoids a false wake
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        dp_s1_r <= 1'h1;
        dp_s2_r <= 1'h1;
    end else begin
        dp_s1_r <= dp_pad;
        dp_s2_r <= dp_s1_r;
    end
end

// ==========================================
// burst end synchroniser and edge detect
// level in, one pulse out per rising edge of burst end
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        bd_s1_r <= {NUM_EP{1'b0}};
        bd_s2_r <= {NUM_EP{1'b0}};
        bd_d_r <= {NUM_EP{1'b0}};
    end else begin
        bd_s1_r <= dma_burst_done;
        bd_s2_r <= bd_s1_r;
        bd_d_r <= bd_s2_r;
    end
end

// ==========================================
// control registers
reg [1:0] sie_raw_r;
reg [1:0] sie_en_r;
reg [1:0] power_state_r;
reg [4:0] lpm_info_r;
reg [3:0] buf_size_r;
reg [NUM_EP-1:0] ep_dir_in_r;
reg [1:0] ep_mode_r [0:NUM_EP-1];
reg [7:0] cnt_hi_r [0:NUM_EP-1];
reg [7:0] cnt_lo_r [0:NUM_EP-1];
reg [4:0] arb_raw_r [0:NUM_EP-1];
reg [4:0] arb_en_r [0:NUM_EP-1];
reg [15:0] wr_cnt_r [0:NUM_EP-1];
reg [15:0] ded_fill_r [0:NUM_EP-1];
reg [NUM_EP-1:0] pending_r;
reg [NUM_EP-1:0] common_busy_r;

wire wr_sie_raw = reg_wr && (reg_addr == `UEV_ADDR_SIE_RAW);
wire active_mode = (power_state_r == `UEV_PWR_ACTIVE);
wire wake_ev = active_mode && !dp_s2_r;
wire [1:0] sie_set = {wake_ev, lpm_token_rx};
wire [1:0] sie_gated = sie_en_r & sie_raw_r;

// ==========================================
// sie raw events, set wins over a clearing write
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        sie_raw_r <= 2'h0;
    end else if (wr_sie_raw) begin
        sie_raw_r <= (sie_raw_r & ~reg_wdata[1:0]) | sie_set;
    end else begin
        sie_raw_r <= sie_raw_r | sie_set;
    end
end

// ==========================================
// lowpower request info, kept until the next token
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        lpm_info_r <= 5'h00;
    end else if (lpm_token_rx) begin
        lpm_info_r <= {lpm_remote_wake, lpm_besl};
    end
end

// ==========================================
// power state; wake fires only when active, so only a write leaves suspend and lowpower sleep
// a firmware write in the wake cycle wins, so sleep entry is never lost
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        power_state_r <= `UEV_PWR_ACTIVE;
    end else if (reg_wr && reg_addr == `UEV_ADDR_POWER) begin
        power_state_r <= reg_wdata[1:0];
    end else if (wake_ev) begin
        power_state_r <= `UEV_PWR_ACTIVE;
    end
end

// ==========================================
// common configuration
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        sie_en_r <= 2'h0;
        buf_size_r <= 4'h0;
        ep_dir_in_r <= {NUM_EP{1'b0}};
    end else begin
        if (reg_wr && reg_addr == `UEV_ADDR_SIE_EN) begin
            sie_en_r <= reg_wdata[1:0];
        end
        if (reg_wr && reg_addr == `UEV_ADDR_BUF_SIZE) begin
            buf_size_r <= reg_wdata[3:0];
        end
        if (reg_wr && reg_addr == `UEV_ADDR_EP_DIR) begin
            ep_dir_in_r <= reg_wdata[NUM_EP-1:0];
        end
    end
end

// ==========================================
// per endpoint arbiter status
// dedicated space is the size field plus one byte
wire [15:0] ded_size = {12'h000, buf_size_r} + 16'h0001;
wire fw_req_wr = reg_wr && (reg_addr == `UEV_ADDR_DMA_REQ);
wire [NUM_EP-1:0] arb_any;

genvar g;
generate
for (g = 0; g < NUM_EP; g = g + 1) begin : g_ep
    // ==========================================
    // per endpoint decode and event sources
    wire auto_m = (ep_mode_r[g] == `UEV_MODE_AUTO);
    wire dma_m = (ep_mode_r[g] == `UEV_MODE_MANUAL_DMA) || auto_m;
    wire is_in = ep_dir_in_r[g];
    wire fw_req = fw_req_wr && reg_wdata[g];
    wire new_req = fw_req || (auto_m && ep_arb_dma_req[g]);
    wire [15:0] prog = {cnt_hi_r[g], cnt_lo_r[g]};
    wire [15:0] wr_next = wr_cnt_r[g] + 16'h0001;
    wire [15:0] ded_next = ded_fill_r[g] + 16'h0001;
    wire grant_set = dma_m && pending_r[g] && burst_pulse[g];
    wire full_sf = !auto_m && ep_byte_wr[g] && (wr_next == prog);
    wire full_ct = auto_m && ep_byte_wr[g] && (ded_next == ded_size);
    wire full_set = is_in && (full_sf || full_ct);
    // fill count stops at the dedicated size, so each extra byte overflows
    wire ovf_in = is_in && ep_byte_wr[g] && (ded_fill_r[g] >= ded_size);
    wire ovf_out = !is_in && ep_out_done[g] && common_busy_r[g];
    wire ovf_set = auto_m && (ovf_in || ovf_out || ep_common_ovf[g]);
    wire unf_set = auto_m && is_in && (ep_dedicated_unf[g] || ep_common_unf[g]);
    // termination is reported in every transfer mode
    wire term_set = ep_dma_termin[g];
    wire [4:0] set_v = {term_set, unf_set, ovf_set, full_set, grant_set};
    wire clr = reg_wr && (reg_addr == `UEV_ADDR_ARB_RAW_BASE + g);

    // ==========================================
    // endpoint mode and byte count registers
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ep_mode_r[g] <= `UEV_RST_MODE;
            cnt_hi_r[g] <= 8'h00;
            cnt_lo_r[g] <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `UEV_ADDR_EP_MODE_BASE + g) begin
                ep_mode_r[g] <= reg_wdata[1:0];
            end
            if (reg_wr && reg_addr == `UEV_ADDR_EP_CNT_HI_BASE + g) begin
                cnt_hi_r[g] <= reg_wdata[7:0];
            end
            if (reg_wr && reg_addr == `UEV_ADDR_EP_CNT_LO_BASE + g) begin
                cnt_lo_r[g] <= reg_wdata[7:0];
            end
        end
    end

    // ==========================================
    // arbiter source enables
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            arb_en_r[g] <= 5'h00;
        end else if (reg_wr && reg_addr == `UEV_ADDR_ARB_EN_BASE + g) begin
            arb_en_r[g] <= reg_wdata[4:0];
        end
    end

    // ==========================================
    // raw arbiter status, set wins over a clearing write
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            arb_raw_r[g] <= 5'h00;
        end else if (clr) begin
            arb_raw_r[g] <= (arb_raw_r[g] & ~reg_wdata[4:0]) | set_v;
        end else begin
            arb_raw_r[g] <= arb_raw_r[g] | set_v;
        end
    end

    // ==========================================
    // byte counts restart when an in token drains the endpoint
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_cnt_r[g] <= 16'h0000;
            ded_fill_r[g] <= 16'h0000;
            common_busy_r[g] <= 1'b0;
        end else begin
            if (ep_in_token[g]) begin
                wr_cnt_r[g] <= 16'h0000;
                ded_fill_r[g] <= 16'h0000;
            end else if (ep_byte_wr[g]) begin
                wr_cnt_r[g] <= wr_next;
                if (ded_fill_r[g] < ded_size) begin
                    ded_fill_r[g] <= ded_next;
                end
            end
            // common area stays occupied until terminate reports it read
            if (ep_out_done[g]) begin
                common_busy_r[g] <= 1'b1;
            end else if (ep_dma_termin[g]) begin
                common_busy_r[g] <= 1'b0;
            end
        end
    end

    // ==========================================
    // dma handshake, later requests dropped until the grant returns
    // mode 1 has no channel, so its requests never leave the block
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pending_r[g] <= 1'b0;
            dma_req[g] <= 1'b0;
        end else begin
            dma_req[g] <= 1'b0;
            if (grant_set) begin
                pending_r[g] <= 1'b0;
            end else if (dma_m && new_req && !pending_r[g]) begin
                pending_r[g] <= 1'b1;
                dma_req[g] <= 1'b1;
            end
        end
    end

    assign arb_any[g] = |(arb_raw_r[g] & arb_en_r[g]);
end
endgenerate

// ==========================================
// serial engine interrupt line
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        sie_irq <= 1'b0;
    end else begin
        sie_irq <= |sie_gated;
    end
end

// ==========================================
// arbiter interrupt line
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        arb_irq <= 1'b0;
    end else begin
        arb_irq <= |arb_any;
    end
end

// ==========================================
// wake request, the wake event registered one cycle later, high as long as the event lasts
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        wake_request <= 1'b0;
    end else begin
        wake_request <= wake_ev;
    end
end

// ==========================================
// read mux, unmapped words read as zero
reg [31:0] rd_nxt;
always @* begin
    rd_nxt = `UEV_RST_WORD;
    case (reg_addr)
        `UEV_ADDR_SIE_RAW: rd_nxt = {30'h0, sie_raw_r};
        `UEV_ADDR_SIE_EN: rd_nxt = {30'h0, sie_en_r};
        `UEV_ADDR_SIE_GATED: rd_nxt = {30'h0, sie_gated};
        `UEV_ADDR_POWER: rd_nxt = {30'h0, power_state_r};
        `UEV_ADDR_LPM_INFO: rd_nxt = {27'h0, lpm_info_r};
        `UEV_ADDR_ARB_GATED: rd_nxt = {{(32-NUM_EP){1'b0}}, arb_any};
        `UEV_ADDR_BUF_SIZE: rd_nxt = {28'h0, buf_size_r};
        `UEV_ADDR_DMA_REQ: rd_nxt = {{(32-NUM_EP){1'b0}}, pending_r};
        `UEV_ADDR_EP_DIR: rd_nxt = {{(32-NUM_EP){1'b0}}, ep_dir_in_r};
        default: begin
            if (reg_addr[7:4] == 4'h1 && reg_addr[3:0] < NUM_EP) begin
                rd_nxt = {27'h0, arb_raw_r[reg_addr[2:0]]};
            end else if (reg_addr[7:4] == 4'h2 && reg_addr[3:0] < NUM_EP) begin
                rd_nxt = {27'h0, arb_en_r[reg_addr[2:0]]};
            end else if (reg_addr[7:4] == 4'h4 && reg_addr[3:0] < NUM_EP) begin
                rd_nxt = {30'h0, ep_mode_r[reg_addr[2:0]]};
            end else if (reg_addr[7:4] == 4'h5 && reg_addr[3:0] < NUM_EP) begin
                rd_nxt = {24'h0, cnt_hi_r[reg_addr[2:0]]};
            end else if (reg_addr[7:4] == 4'h6 && reg_addr[3:0] < NUM_EP) begin
                rd_nxt = {24'h0, cnt_lo_r[reg_addr[2:0]]};
            end
        end
    endcase
end

// ==========================================
// read data stands one cycle only, zero otherwise
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        reg_rdata <= `UEV_RST_WORD;
    end else if (reg_rd) begin
        reg_rdata <= rd_nxt;
    end else begin
        reg_rdata <= `UEV_RST_WORD;
    end
end

endmodule // uev_event_ctrl

// ==== dv/uev_chk_asserts.sv ====
`timescale 1ns/1ps
// ==========
// checker
module uev_chk #(
    parameter NUM_EP = 8
) (
    // clock, reset, register port
    input wire clk_sys,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // events
    input wire lpm_token_rx,
    input wire dp_pad,
    input wire [NUM_EP-1:0] ep_byte_wr,
    input wire [NUM_EP-1:0] ep_out_done,
    input wire [NUM_EP-1:0] ep_common_ovf,
    input wire [NUM_EP-1:0] ep_dedicated_unf,
    input wire [NUM_EP-1:0] ep_common_unf,
    input wire [NUM_EP-1:0] ep_arb_dma_req,
    input wire [NUM_EP-1:0] ep_dma_termin,
    // dma and interrupts
    input wire [NUM_EP-1:0] dma_burst_done,
    input wire [NUM_EP-1:0] dma_req,
    input wire sie_irq,
    input wire arb_irq,
    input wire wake_request
);
    reg [NUM_EP-1:0] pend_r;
    reg [NUM_EP-1:0] done_q_r;
    reg [NUM_EP-1:0] arb_en_r;
    reg [1:0] sie_en_r;
    reg [3:0] sie_age_r;
    reg [3:0] arb_age_r;
    wire dreq_wr = reg_wr && reg_addr == 8'h71;
    wire sie_ev = lpm_token_rx || !dp_pad || reg_wr;
    wire arb_ev = reg_wr || |{ep_byte_wr, ep_out_done, ep_common_ovf, ep_dedicated_unf,
        ep_common_unf, ep_dma_termin, dma_burst_done};
    // pending clears early here, so it only ever errs on the lenient side
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_r <= {NUM_EP{1'b0}};
            done_q_r <= {NUM_EP{1'b0}};
            arb_en_r <= {NUM_EP{1'b0}};
            sie_en_r <= 2'h0;
            sie_age_r <= 4'hF;
            arb_age_r <= 4'hF;
        end else begin
            done_q_r <= dma_burst_done;
            pend_r <= (pend_r | dma_req) & ~(dma_burst_done & ~done_q_r);
            if (reg_wr && reg_addr == 8'h01) begin
                sie_en_r <= reg_wdata[1:0];
            end
            if (reg_wr && reg_addr[7:4] == 4'h2 && reg_addr[3:0] < NUM_EP) begin
                arb_en_r[reg_addr[2:0]] <= |reg_wdata[4:0];
            end
            sie_age_r <= sie_ev ? 4'h0 : sie_age_r + {3'h0, sie_age_r != 4'hF};
            arb_age_r <= arb_ev ? 4'h0 : arb_age_r + {3'h0, arb_age_r != 4'hF};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_reset_quiet: assert property ($past(rst) |-> dma_req == 0 && !sie_irq && !arb_irq)
        else $error("output active right after reset");
    a_req_cause: assert property (
        (dma_req & ~$past(ep_arb_dma_req | (reg_wdata[NUM_EP-1:0] & {NUM_EP{dreq_wr}}))) == 0)
        else $error("dma request without cause");
    a_req_once: assert property ((dma_req & pend_r) == 0)
        else $error("request forwarded while pending");
    a_sie_gate: assert property (sie_irq |-> $past(sie_en_r) != 2'h0)
        else $error("serial event irq without enable");
    a_arb_gate: assert property (arb_irq |-> $past(arb_en_r) != 0)
        else $error("arbiter irq without enable");
    a_sie_cause: assert property ($rose(sie_irq) |-> sie_age_r <= 4'h6)
        else $error("serial event irq without event");
    a_arb_cause: assert property ($rose(arb_irq) |-> arb_age_r <= 4'h7)
        else $error("arbiter irq without event");
    a_wake_pad: assert property (wake_request |-> !$past(dp_pad, 3))
        else $error("wake request without low pad");
    c_wake: cover property ($rose(wake_request));
    c_dma_req: cover property (|dma_req);
    c_sie_irq: cover property ($rose(sie_irq));
    c_arb_irq: cover property ($rose(arb_irq));
endmodule // uev_chk
bind uev_event_ctrl uev_chk #(.NUM_EP(NUM_EP)) chk_u (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lpm_token_rx(lpm_token_rx), .dp_pad(dp_pad),
    .ep_byte_wr(ep_byte_wr), .ep_out_done(ep_out_done), .ep_common_ovf(ep_common_ovf),
    .ep_dedicated_unf(ep_dedicated_unf), .ep_common_unf(ep_common_unf),
    .ep_arb_dma_req(ep_arb_dma_req), .ep_dma_termin(ep_dma_termin),
    .dma_burst_done(dma_burst_done), .dma_req(dma_req), .sie_irq(sie_irq), .arb_irq(arb_irq),
    .wake_request(wake_request));

// ==== dv/uev_dma_model.sv ====
`timescale 1ns/1ps
// ==========
// dma channels, one per endpoint
module uev_dma_model #(
    parameter NUM_EP = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // handshake
    input wire [NUM_EP-1:0] dma_req,
    input wire slow,
    output reg [NUM_EP-1:0] dma_burst_done
);
    reg [5:0] cnt_r [0:NUM_EP-1];
    integer i;
    // burst end held two cycles so the input synchroniser cannot miss it
    always @(posedge clk_sys or posedge rst) begin
        for (i = 0; i < NUM_EP; i = i + 1) begin
            if (rst) begin
                cnt_r[i] <= 6'h00;
                dma_burst_done[i] <= 1'b0;
            end else begin
                if (dma_req[i]) begin
                    cnt_r[i] <= slow ? 6'h1E : 6'h03;
                end else if (cnt_r[i] != 6'h00) begin
                    cnt_r[i] <= cnt_r[i] - 6'h01;
                end
                dma_burst_done[i] <= cnt_r[i] == 6'h02 || cnt_r[i] == 6'h01;
            end
        end
    end
endmodule // uev_dma_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
// ==========
// bench
module tb;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg lpm_token_rx = 1'b0;
    reg [3:0] lpm_besl = 4'h0;
    reg lpm_remote_wake = 1'b0;
    reg dp_pad = 1'b1;
    reg slow = 1'b0;
    reg [7:0] ev [0:7];
    wire [31:0] reg_rdata;
    wire [7:0] dma_req;
    wire [7:0] dma_burst_done;
    wire sie_irq;
    wire arb_irq;
    wire wake_request;
    integer n_wake = 0;
    integer n_fail = 0;
    integer checks_done = 0;
    integer n_req = 0;
    integer cyc = 0;
    integer i;
    always #50 clk_sys = ~clk_sys;
    uev_event_ctrl #(.NUM_EP(8)) dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .lpm_token_rx(lpm_token_rx), .lpm_besl(lpm_besl), .lpm_remote_wake(lpm_remote_wake),
        .dp_pad(dp_pad), .ep_byte_wr(ev[0]), .ep_in_token(ev[1]), .ep_out_done(ev[2]),
        .ep_common_ovf(ev[3]), .ep_dedicated_unf(ev[4]), .ep_common_unf(ev[5]),
        .ep_arb_dma_req(ev[6]), .ep_dma_termin(ev[7]), .dma_burst_done(dma_burst_done),
        .dma_req(dma_req), .sie_irq(sie_irq), .arb_irq(arb_irq),
        .wake_request(wake_request));
    uev_dma_model #(.NUM_EP(8)) dma_u (.clk_sys(clk_sys), .rst(rst), .dma_req(dma_req),
        .slow(slow), .dma_burst_done(dma_burst_done));
    // ==========
    // helpers
    task report_and_stop;
        begin
            if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        n_req <= n_req + $countones(dma_req);
        n_wake <= n_wake + wake_request;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            report_and_stop;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            @(negedge clk_sys);
            chk(reg_rdata, exp);
        end
    endtask
    task pulse(input integer k, input [7:0] m, input integer n);
        repeat (n) begin
            @(posedge clk_sys);
            ev[k] <= m;
            @(posedge clk_sys);
            ev[k] <= 8'h00;
        end
    endtask
    // ==========
    // scenarios
    task t_reset;
        begin
            rd(8'h00, 0);
            rd(8'h40, 1);
            rd(8'h03, 0);
            rd(8'hFF, 0);
        end
    endtask
    task t_lpm;
        begin
            @(posedge clk_sys);
            lpm_besl <= 4'hA;
            lpm_remote_wake <= 1'b1;
            lpm_token_rx <= 1'b1;
            @(posedge clk_sys);
            lpm_token_rx <= 1'b0;
            rd(8'h00, 1);
            rd(8'h02, 0);
            wr(8'h01, 3);
            rd(8'h02, 1);
            chk(sie_irq, 1);
            rd(8'h04, 32'h1A);
            wr(8'h00, 0);
            rd(8'h00, 1);
            wr(8'h00, 1);
            rd(8'h00, 0);
        end
    endtask
    task t_wake(input [1:0] pwr, input [31:0] exp);
        integer n0;
        begin
            wr(8'h03, pwr);
            n0 = n_wake;
            dp_pad <= 1'b0;
            repeat (4) @(posedge clk_sys);
            dp_pad <= 1'b1;
            rd(8'h00, exp);
            rd(8'h02, exp);
            chk(n_wake - n0, (exp != 0) ? 4 : 0);
            wr(8'h00, 2);
        end
    endtask
    task t_dma(input [2:0] e, input [1:0] mode, input s, input [31:0] exp);
        integer n0;
        begin
            wr(8'h40 + e, mode);
            wr(8'h20 + e, 1);
            slow <= s;
            n0 = n_req;
            if (mode == 2'h3) pulse(6, 8'h01 << e, 1);
            else wr(8'h71, 8'h01 << e);
            wr(8'h71, 8'h01 << e);
            repeat (45) @(posedge clk_sys);
            chk(n_req - n0, exp);
            rd(8'h10 + e, exp);
            rd(8'h30, exp << e);
            chk(arb_irq, exp);
            wr(8'h10 + e, 32'h1F);
            wr(8'h20 + e, 0);
        end
    endtask
    task t_buf;
        begin
            wr(8'h72, 8'h18);
            wr(8'h63, 3);
            wr(8'h67, 1);
            pulse(0, 8'h08, 2);
            rd(8'h13, 0);
            pulse(0, 8'h88, 1);
            rd(8'h13, 2);
            rd(8'h17, 0);
            pulse(0, 8'h08, 1);
            pulse(4, 8'h08, 1);
            rd(8'h13, 2);
            wr(8'h44, 3);
            wr(8'h70, 1);
            pulse(0, 8'h10, 2);
            rd(8'h14, 2);
            pulse(0, 8'h10, 1);
            rd(8'h14, 6);
            pulse(4, 8'h10, 1);
            pulse(7, 8'h10, 1);
            rd(8'h14, 32'h1E);
            wr(8'h45, 3);
            wr(8'h46, 3);
            pulse(2, 8'h20, 2);
            pulse(3, 8'h40, 1);
            rd(8'h15, 4);
            rd(8'h16, 4);
        end
    endtask
    initial begin
        for (i = 0; i < 8; i = i + 1) ev[i] = 8'h00;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        t_lpm;
        t_wake(2'h0, 2);
        t_wake(2'h2, 0);
        wr(8'h03, 0);
        t_dma(3'h0, 2'h2, 1'b0, 1);
        t_dma(3'h2, 2'h3, 1'b1, 1);
        t_dma(3'h1, 2'h1, 1'b1, 0);
        t_buf;
        report_and_stop;
    end
endmodule // tb
